// *** clee_engine.sv ***
// Operation
// R1: Each equation picks four inputs from one shared signal pool.
// R2: Each of the four inputs has its own inversion bit.
// R3: Gate result passes through separate on and off delays.
// R4: Each equation drives a direct output and a latched output.
// R5: Inverted copy of the latched output is also provided.
// R6: Latch reset is chosen from the pool and can be inverted.
// R7: Reset beats set when both are active.
// R8: Equations are evaluated lowest index first, pass after pass.
// R9: Any equation output can feed any equation input.
// R10: Lower index producer gives its value from the same pass.
// R11: Higher index producer gives its value from the previous pass.
// R12: Inputs and outputs of every equation are readable.
// R13: Delayed output changes only after the result held for the delay.
// R14: Gate is AND, OR, NAND or NOR of the four inputs.
`timescale 1ns/1ps
module clee_engine import clee_pkg::*; #(
  parameter int unsigned NEQ = CLEE_NEQ_MAX
) (
  // Clock, reset and enable
  input  wire logic            CLOCK,
  input  wire logic            RST_N,
  input  wire logic            CE,
  // APB slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [11:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  // Pool of device signals
  input  wire logic [CLEE_NEXT-1:0] EXT_IN,
  // Equation outputs
  output logic      [NEQ-1:0]  LE_OUT,
  output logic      [NEQ-1:0]  LE_LATCH,
  output logic      [NEQ-1:0]  LE_LATCH_N
);
  localparam int unsigned IDX_W = (NEQ > 1) ? $clog2(NEQ) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NEQ - 1);

  typedef struct packed {
    logic                                 run;
    logic [IDX_W-1:0]                     idx;
    logic [31:0]                          pass;
    logic [NEQ-1:0][29:0]                 sel;
    logic [NEQ-1:0][6:0]                  ctl;
    logic [NEQ-1:0][31:0]                 dly;
    logic [NEQ-1:0][CLEE_DLY_W-1:0]       cnt;
    logic [NEQ-1:0]                       out;
    logic [NEQ-1:0]                       lat;
    logic [NEQ-1:0]                       latn;
    logic [NEQ-1:0][CLEE_STAT_W-1:0]      stat;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
  } clee_state_t;

  typedef struct packed {
    logic             hit;
    logic             glob;
    logic [IDX_W-1:0] eq;
    logic [1:0]       fld;
  } clee_dec_t;

  clee_state_t    s;
  clee_state_t    next_s;
  clee_eval_in_t  ev_in;
  clee_eval_out_t ev_out;
  logic [1:0]     rst_q;
  logic           rst_n_sync;

  // Picks the six-bit selector of slot k from a selector word
  function automatic logic [CLEE_SEL_W-1:0] sel_field(input logic [29:0] w,
                                                      input int unsigned k);
    sel_field = w[k*CLEE_SEL_W +: CLEE_SEL_W];
  endfunction : sel_field

  // Address decode shared by the read and write paths
  function automatic clee_dec_t decode(input logic [11:0] a);
    clee_dec_t d;
    logic [3:0] eqn;
    d     = '0;
    eqn   = a[7:4];
    d.fld = a[3:2];
    d.eq  = eqn[IDX_W-1:0];
    if (a[11:4] == 8'h00) begin
      d.hit  = 1'b1;
      d.glob = 1'b1;
    end else if (a[11:8] == CLEE_EQ_BASE[11:8] && {28'h0, eqn} < NEQ) begin
      d.hit = 1'b1;
    end
    decode = d;
  endfunction : decode

  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 2'h0;
    end else if (CE) begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_q[1];

  // Single evaluator shared by all equations, one per clock
  clee_eval u_eval (
    .ev_in  (ev_in),
    .ev_out (ev_out)
  );

  always_comb begin
    logic [63:0]      pool;
    logic [7:0]       pad_out;
    logic [7:0]       pad_lat;
    logic [7:0]       pad_latn;
    logic [29:0]      cur_sel;
    logic [6:0]       cur_ctl;
    logic [31:0]      cur_dly;
    clee_dec_t        dec;
    logic [31:0]      rd;
    pool     = '0;
    cur_sel  = '0;
    cur_ctl  = '0;
    cur_dly  = '0;
    dec      = '0;
    rd       = '0;
    pad_out  = '0;
    pad_lat  = '0;
    pad_latn = '0;
    next_s   = s;
    // Pool holds live stored outputs: earlier equations already hold this
    // pass's value, later ones still hold the previous pass's value
    pad_out[NEQ-1:0]  = s.out; // R9
    pad_lat[NEQ-1:0]  = s.lat;
    pad_latn[NEQ-1:0] = s.latn;
    pool = {8'h0, pad_latn, pad_lat, pad_out, EXT_IN}; // R10 R11
    cur_sel = s.sel[s.idx];
    cur_ctl = s.ctl[s.idx];
    cur_dly = s.dly[s.idx];
    // Route pool signals to the equation under evaluation
    ev_in = '0;
    for (int unsigned k = 0; k < CLEE_NIN; k++) begin
      ev_in.raw[k] = pool[sel_field(cur_sel, k)]; // R1
    end
    ev_in.inv     = cur_ctl[3:0];
    ev_in.gate    = clee_gate_t'(cur_ctl[CLEE_CTL_GATE +: 2]);
    ev_in.on_dly  = cur_dly[CLEE_DLY_W-1:0];
    ev_in.off_dly = cur_dly[CLEE_DLY_OFF +: CLEE_DLY_W];
    ev_in.cnt     = s.cnt[s.idx];
    ev_in.out     = s.out[s.idx];
    ev_in.rst_raw = pool[cur_sel[CLEE_SEL_RST +: CLEE_SEL_W]]; // R6
    ev_in.rst_inv = cur_ctl[CLEE_CTL_RINV];
    ev_in.latch   = s.lat[s.idx];
    // Step the scan: one equation per clock, ascending, wrapping
    if (s.run) begin
      next_s.cnt[s.idx]  = ev_out.cnt;
      next_s.out[s.idx]  = ev_out.out; // R4
      next_s.lat[s.idx]  = ev_out.latch; // R4
      next_s.latn[s.idx] = ~ev_out.latch; // R5
      next_s.stat[s.idx] = {ev_out.gate_res, ev_out.cond}; // R12
      if (s.idx == IDX_LAST) begin // R8
        next_s.idx  = '0;
        next_s.pass = s.pass + 32'h1;
      end else begin
        next_s.idx = s.idx + IDX_W'(1); // R8
      end
    end
    // APB: answer one cycle into the access phase
    dec            = decode(PADDR);
    rd             = '0;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0; // Error only stands beside ready, never lingers
    if (PSEL && PENABLE && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !dec.hit;
      if (dec.glob) begin
        case (PADDR[3:0])
          CLEE_OFF_CTRL[3:0]: rd[CLEE_CTRL_RUN] = s.run;
          CLEE_OFF_PASS[3:0]: rd = s.pass;
          CLEE_OFF_OUTS[3:0]: rd = {8'h0, pad_latn, pad_lat, pad_out}; // R12
          CLEE_OFF_EXT[3:0]:  rd = EXT_IN; // R12
          default:            rd = '0;
        endcase
      end else if (dec.hit) begin
        case (dec.fld)
          CLEE_EQ_SEL:  rd = {2'h0, s.sel[dec.eq]};
          CLEE_EQ_CTL:  rd = {25'h0, s.ctl[dec.eq]};
          CLEE_EQ_DLY:  rd = s.dly[dec.eq];
          CLEE_EQ_STAT: rd = {24'h0, s.latn[dec.eq], s.lat[dec.eq],
                              s.out[dec.eq], s.stat[dec.eq]}; // R12
          default:      rd = '0;
        endcase
      end
      next_s.prdata = rd;
    end
    // Writes land on the edge that completes the transfer
    if (PSEL && PENABLE && s.pready && PWRITE && dec.hit) begin
      if (dec.glob) begin
        if (PADDR[3:0] == CLEE_OFF_CTRL[3:0]) begin
          next_s.run = PWDATA[CLEE_CTRL_RUN];
        end
      end else begin
        case (dec.fld)
          CLEE_EQ_SEL: next_s.sel[dec.eq] = PWDATA[29:0];
          CLEE_EQ_CTL: next_s.ctl[dec.eq] = PWDATA[6:0];
          CLEE_EQ_DLY: next_s.dly[dec.eq] = PWDATA;
          default:     next_s.run = next_s.run; // Status is read only
        endcase
      end
    end
  end

  // All block state; CE low holds everything
  always_ff @(posedge CLOCK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s      <= '0;
      s.run  <= CLEE_RUN_RST_VAL;
      s.sel  <= {NEQ{CLEE_SEL_RST_VAL}};
      s.ctl  <= {NEQ{CLEE_CTL_RST_VAL}};
      s.dly  <= {NEQ{CLEE_DLY_RST_VAL}};
      s.latn <= '1; // Latch starts clear, so its inverse starts high
    end else if (CE) begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign PRDATA     = s.prdata;
  assign PREADY     = s.pready;
  assign PSLVERR    = s.pslverr;
  assign LE_OUT     = s.out;
  assign LE_LATCH   = s.lat;
  assign LE_LATCH_N = s.latn;
endmodule : clee_engine

// *** clee_eval.sv ***
package clee_pkg;
  // Sizes of the equation bank and its signal pool
  localparam int unsigned CLEE_NEQ_MAX  = 8;
  localparam int unsigned CLEE_NEXT     = 32;
  localparam int unsigned CLEE_NIN      = 4;
  localparam int unsigned CLEE_SEL_W    = 6;
  localparam int unsigned CLEE_DLY_W    = 16;
  localparam int unsigned CLEE_STAT_W   = 5;
  // Pool map: external inputs, then outputs, latched and inverted latched
  localparam logic [5:0]  CLEE_POOL_OUT  = 6'h20;
  localparam logic [5:0]  CLEE_POOL_LAT  = 6'h28;
  localparam logic [5:0]  CLEE_POOL_LATN = 6'h30;
  // Register offsets (byte addresses)
  localparam logic [11:0] CLEE_OFF_CTRL  = 12'h000;
  localparam logic [11:0] CLEE_OFF_PASS  = 12'h004;
  localparam logic [11:0] CLEE_OFF_OUTS  = 12'h008;
  localparam logic [11:0] CLEE_OFF_EXT   = 12'h00c;
  localparam logic [11:0] CLEE_EQ_BASE   = 12'h100;
  localparam logic [1:0]  CLEE_EQ_SEL    = 2'h0;
  localparam logic [1:0]  CLEE_EQ_CTL    = 2'h1;
  localparam logic [1:0]  CLEE_EQ_DLY    = 2'h2;
  localparam logic [1:0]  CLEE_EQ_STAT   = 2'h3;
  // Field positions
  localparam int unsigned CLEE_SEL_RST   = 24;
  localparam int unsigned CLEE_CTL_RINV  = 4;
  localparam int unsigned CLEE_CTL_GATE  = 5;
  localparam int unsigned CLEE_DLY_OFF   = 16;
  localparam int unsigned CLEE_CTRL_RUN  = 0;
  // Reset values
  localparam logic [29:0] CLEE_SEL_RST_VAL = 30'h0;
  localparam logic [6:0]  CLEE_CTL_RST_VAL = 7'h0;
  localparam logic [31:0] CLEE_DLY_RST_VAL = 32'h0;
  localparam logic        CLEE_RUN_RST_VAL = 1'b0;

  typedef enum logic [1:0] {
    CLEE_GATE_AND  = 2'h0,
    CLEE_GATE_OR   = 2'h1,
    CLEE_GATE_NAND = 2'h2,
    CLEE_GATE_NOR  = 2'h3
  } clee_gate_t;

  typedef struct packed {
    logic [3:0]            raw;
    logic [3:0]            inv;
    clee_gate_t            gate;
    logic [CLEE_DLY_W-1:0] on_dly;
    logic [CLEE_DLY_W-1:0] off_dly;
    logic [CLEE_DLY_W-1:0] cnt;
    logic                  out;
    logic                  rst_raw;
    logic                  rst_inv;
    logic                  latch;
  } clee_eval_in_t;

  typedef struct packed {
    logic [3:0]            cond;
    logic                  gate_res;
    logic [CLEE_DLY_W-1:0] cnt;
    logic                  out;
    logic                  latch;
  } clee_eval_out_t;
endpackage : clee_pkg

`timescale 1ns/1ps
// One evaluation step of a single equation, pure logic
module clee_eval import clee_pkg::*; (
  // Present state and configuration
  input  wire clee_eval_in_t  ev_in,
  // Next state
  output clee_eval_out_t      ev_out
);
  logic [CLEE_DLY_W:0] cnt_inc;
  logic [CLEE_DLY_W:0] dly_ext;
  logic                rst_act;

  always_comb begin
    ev_out      = '0;
    ev_out.cond = ev_in.raw ^ ev_in.inv; // R2
    // Gate on the conditioned inputs
    case (ev_in.gate) // R14
      CLEE_GATE_AND:  ev_out.gate_res = &ev_out.cond;
      CLEE_GATE_OR:   ev_out.gate_res = |ev_out.cond;
      CLEE_GATE_NAND: ev_out.gate_res = ~&ev_out.cond;
      CLEE_GATE_NOR:  ev_out.gate_res = ~|ev_out.cond;
      default:        ev_out.gate_res = 1'b0;
    endcase
    // On/off delay counted in whole passes; 0 and 1 both act at once
    cnt_inc = {1'b0, ev_in.cnt} + {{CLEE_DLY_W{1'b0}}, 1'b1};
    dly_ext = ev_out.gate_res ? {1'b0, ev_in.on_dly} : {1'b0, ev_in.off_dly};
    ev_out.out = ev_in.out;
    ev_out.cnt = '0;
    if (ev_out.gate_res != ev_in.out) begin // R3
      if (cnt_inc >= dly_ext) begin // R13
        ev_out.out = ev_out.gate_res;
      end else begin
        ev_out.cnt = cnt_inc[CLEE_DLY_W-1:0]; // R13
      end
    end
    // Reset dominant latch fed by the delayed output
    rst_act      = ev_in.rst_raw ^ ev_in.rst_inv; // R6
    ev_out.latch = rst_act ? 1'b0 : (ev_in.latch | ev_out.out); // R7
  end
endmodule : clee_eval

// *** clee_engine_asserts.sv ***
`timescale 1ns/1ps
// Port-level checks of the equation engine
module clee_engine_asserts import clee_pkg::*; #(
  parameter int unsigned NEQ = CLEE_NEQ_MAX
) (
  // Clock and control
  input wire logic           CLOCK,
  input wire logic           RST_N,
  input wire logic           CE,
  // APB
  input wire logic           PSEL,
  input wire logic           PENABLE,
  input wire logic           PWRITE,
  input wire logic [11:0]    PADDR,
  input wire logic [31:0]    PWDATA,
  input wire logic [31:0]    PRDATA,
  input wire logic           PREADY,
  input wire logic           PSLVERR,
  // Pool and equation outputs
  input wire logic [31:0]    EXT_IN,
  input wire logic [NEQ-1:0] LE_OUT,
  input wire logic [NEQ-1:0] LE_LATCH,
  input wire logic [NEQ-1:0] LE_LATCH_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Access phase still waiting
  sequence s_wait; PSEL && PENABLE && !PREADY; endsequence
  // Answer stands one cycle only
  sequence s_ans; PREADY ##1 !PREADY; endsequence
  AST_ONE_WAIT: assert property (s_wait |=> s_ans) else $error("answer timing wrong");
  AST_READY_REQ: assert property (PREADY |-> PSEL && PENABLE) else $error("ready without access");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_RD_ERR_ZERO: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read not zero");
  AST_LATCH_INV: assert property (LE_LATCH_N == ~LE_LATCH) else $error("inverse wrong");
  // One equation per enabled clock, so one output bit at most moves
  AST_ONE_EQ_STEP: assert property ($countones(LE_OUT ^ $past(LE_OUT)) <= 1)
    else $error("several outputs moved");
  AST_LATCH_SET: assert property (((LE_LATCH & ~$past(LE_LATCH)) & ~LE_OUT) == '0)
    else $error("latch set without output");
  AST_FREEZE: assert property (!CE |=> $stable(LE_OUT) && $stable(LE_LATCH))
    else $error("outputs moved while disabled");
endmodule : clee_engine_asserts

bind clee_engine clee_engine_asserts #(.NEQ(NEQ)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_IN(EXT_IN), .LE_OUT(LE_OUT),
  .LE_LATCH(LE_LATCH), .LE_LATCH_N(LE_LATCH_N));

// *** clee_pool_model.sv ***
`timescale 1ns/1ps
// Field side: pickups and breaker states presented as levels
module clee_pool_model (
  // Clock
  input  wire logic        CLOCK,
  // Levels the scenario wants
  input  wire logic [31:0] want,
  // Pool lines into the engine
  output logic      [31:0] ext_in
);
  // Contacts change only after an edge, so sampling never races
  always @(posedge CLOCK) begin
    ext_in <= want;
  end
endmodule : clee_pool_model

// *** tb_cyclic_logic_equation_engine.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_cyclic_logic_equation_engine import clee_pkg::*;;
  localparam int unsigned NEQ = 8;
  logic CLOCK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, pool, EXT_IN, rd;
  logic [NEQ-1:0] LE_OUT, LE_LATCH, LE_LATCH_N;
  logic [1:0] g;
  logic [3:0] inv, s;
  logic [4:0] e;
  int fail_count, num_checks, cyc, seed, t0, t1;

  clee_pool_model i_pool (.CLOCK(CLOCK), .want(pool), .ext_in(EXT_IN));
  clee_engine #(.NEQ(NEQ)) i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_IN(EXT_IN), .LE_OUT(LE_OUT),
    .LE_LATCH(LE_LATCH), .LE_LATCH_N(LE_LATCH_N));

  // 25 MHz clock and a cycle count for timing checks
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) cyc <= cyc + 1;

  // Address of register r of equation i
  function automatic logic [11:0] ea(int i, logic [1:0] r);
    return CLEE_EQ_BASE + 12'(i * 16) + {8'h0, r, 2'b00};
  endfunction : ea

  // Same selector on all four inputs, reset from pool line 0
  function automatic logic [31:0] sel4(logic [5:0] v);
    return {8'h0, {4{v}}};
  endfunction : sel4

  // Expected gate result above the conditioned inputs
  function automatic logic [4:0] f_stat(logic [3:0] raw, logic [3:0] iv, logic [1:0] gt);
    logic [3:0] c;
    c = raw ^ iv;
    case (gt)
      2'h0: return {&c, c};
      2'h1: return {|c, c};
      2'h2: return {~&c, c};
      default: return {~|c, c};
    endcase
  endfunction : f_stat

  // One APB transfer; the answer is sampled where it stands before the edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    // Ready, data and error are taken at the rising edge that samples ready
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Let k enabled clocks pass while the enable drops at random
  task automatic settle(input int k);
    while (k > 0) begin
      @(posedge CLOCK);
      if (CE === 1'b1) k--;
      CE <= ($random(seed) % 4) != 0;
    end
    @(posedge CLOCK);
    CE <= 1'b1;
  endtask : settle

  // Cycle at which output k next toggles, bounded wait
  task automatic flip(input int k, output int t);
    logic v;
    int n;
    v = LE_OUT[k];
    n = 0;
    while (LE_OUT[k] === v && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 400) fail_count++;
    t = cyc;
  endtask : flip

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    seed = 52;
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, pool} = '0;
    CE = 1'b1;
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    // Reset values, then a refused address
    apb(1'b0, CLEE_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, ea(2, CLEE_EQ_DLY), 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, CLEE_OFF_CTRL, 32'h1);
    // Every gate kind over random inputs and inversions, corners first
    apb(1'b1, ea(6, CLEE_EQ_SEL), {8'h0, 6'h0c, 6'h0b, 6'h0a, 6'h09});
    for (int i = 0; i < 12; i++) begin
      g = 2'(i % 4);
      inv = 4'($random(seed));
      apb(1'b1, ea(6, CLEE_EQ_CTL), {25'h0, g, 1'b0, inv});
      @(posedge CLOCK);
      pool <= (i < 4) ? 32'h1e00 : $random(seed);
      settle(3 * NEQ);
      e = f_stat(pool[12:9], inv, g);
      apb(1'b0, ea(6, CLEE_EQ_STAT), 32'h0);
      `CHK(rd[4:0], e)
      `CHK(LE_OUT[6], e[4])
    end
    apb(1'b0, CLEE_OFF_EXT, 32'h0);
    `CHK(rd, pool)
    // Chaining forward within a pass and backward across passes
    apb(1'b1, ea(0, CLEE_EQ_SEL), sel4(6'h07));
    apb(1'b1, ea(0, CLEE_EQ_CTL), 32'h20);
    apb(1'b1, ea(1, CLEE_EQ_SEL), sel4(CLEE_POOL_OUT));
    apb(1'b1, ea(3, CLEE_EQ_SEL), sel4(6'h08));
    apb(1'b1, ea(3, CLEE_EQ_CTL), 32'h20);
    apb(1'b1, ea(2, CLEE_EQ_SEL), sel4(CLEE_POOL_OUT + 6'h3));
    settle(2 * NEQ);
    pool[7] <= ~pool[7];
    flip(0, t0);
    flip(1, t1);
    `CHK(t1 - t0, 1)
    @(posedge CLOCK);
    pool[8] <= ~pool[8];
    flip(3, t0);
    flip(2, t1);
    `CHK(t1 - t0, NEQ - 1)
    // Off delay of 2 passes and on delay of 3 passes
    apb(1'b1, ea(4, CLEE_EQ_SEL), sel4(6'h04));
    apb(1'b1, ea(4, CLEE_EQ_CTL), 32'h20);
    apb(1'b1, ea(4, CLEE_EQ_DLY), {16'd2, 16'd3});
    pool[4] <= 1'b0;
    settle(4 * NEQ);
    pool[4] <= 1'b1;
    flip(4, t0);
    @(posedge CLOCK);
    pool[4] <= 1'b0;
    flip(4, t1);
    `CHK(t1 - t0, 2 * NEQ)
    @(posedge CLOCK);
    pool[4] <= 1'b1;
    flip(4, t0);
    `CHK(t0 - t1, 3 * NEQ)
    // Latch: set {in, reset, reset invert, expected latch} per step
    apb(1'b1, ea(5, CLEE_EQ_SEL), {2'b0, 6'h06, {4{6'h05}}});
    for (int i = 5; i >= 0; i--) begin
      s = 4'(24'h91c6f2 >> (4 * i));
      @(posedge CLOCK);
      pool[6:5] <= {s[2], s[3]};
      settle(2 * NEQ);
      apb(1'b1, ea(5, CLEE_EQ_CTL), {27'h1, s[1], 4'h0});
      settle(2 * NEQ);
      `CHK({LE_LATCH[5], LE_LATCH_N[5], LE_OUT[5]}, {s[0], ~s[0], s[3]})
    end
    apb(1'b0, CLEE_OFF_OUTS, 32'h0);
    `CHK({rd[21], rd[13], rd[5]}, 3'b100)
    // Pass counter moved while running and stands still once stopped
    apb(1'b1, CLEE_OFF_CTRL, 32'h0);
    apb(1'b0, CLEE_OFF_PASS, 32'h0);
    t0 = rd;
    `CHK(t0 > 32, 1'b1)
    settle(2 * NEQ);
    apb(1'b0, CLEE_OFF_PASS, 32'h0);
    `CHK(rd, t0)
    summarize();
  end

  // Watchdog far beyond the thousand or so cycles the run needs
  initial begin
    #1000000;
    fail_count++;
    summarize();
  end
endmodule : tb_cyclic_logic_equation_engine
